// ===== apc_pkg.sv
package apc_pkg;
   // clock and filter timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int WIDTH_SHORT_NS = 150;
   localparam int WIDTH_LONG_NS = 2400;
   localparam int WIDTH_SHORT_CYC =
      (WIDTH_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WIDTH_LONG_CYC =
      (WIDTH_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FILT_CNT_W = 6;
   localparam int NUM_IN = 4;
   localparam int DATA_W = 32;
   // register word addresses
   localparam logic [3:0] ADDR_CMD = 4'h0;
   localparam logic [3:0] ADDR_WIN_OPEN = 4'h1;
   localparam logic [3:0] ADDR_WIN_CLOSE = 4'h2;
   localparam logic [3:0] ADDR_STATUS = 4'h3;
   localparam logic [3:0] ADDR_POS_A = 4'h4;
   localparam logic [3:0] ADDR_POS_B = 4'h5;
   localparam logic [3:0] ADDR_SPD_A = 4'h6;
   localparam logic [3:0] ADDR_SPD_B = 4'h7;
   // arm command codes, field [7:0]
   localparam logic [7:0] CODE_A_FIRST = 8'h01;
   localparam logic [7:0] CODE_A_LAST = 8'h04;
   localparam logic [7:0] CODE_DUAL_FIRST = 8'h06;
   localparam logic [7:0] CODE_DUAL_LAST = 8'h0D;
   localparam logic [7:0] CODE_B_FIRST = 8'h0E;
   localparam logic [7:0] CODE_B_LAST = 8'h11;
   localparam logic [7:0] CODE_WIDTH_LONG = 8'h17;
   localparam logic [7:0] CODE_WIDTH_SHORT = 8'h18;
   // window field [9:8]
   localparam int WIN_LSB = 8;
   localparam logic [1:0] WIN_NONE = 2'h0;
   localparam logic [1:0] WIN_INSIDE = 2'h1;
   localparam logic [1:0] WIN_OUTSIDE = 2'h3;
   // status bit positions
   localparam int ST_FLAG_A = 0;
   localparam int ST_FLAG_B = 1;
   localparam int ST_ARMED_A = 2;
   localparam int ST_ARMED_B = 3;
   localparam int ST_LONG = 4;
   typedef enum logic [1:0] {
      SRC_INDEX = 2'b00,
      SRC_FIRST = 2'b01,
      SRC_SECOND = 2'b10,
      SRC_INDEX2 = 2'b11
   } apc_src_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ARMED = 2'b01,
      ST_DONE = 2'b10
   } apc_state_t;
endpackage : apc_pkg

// ===== apc_chan_if.sv
`timescale 1ns/10ps
interface apc_chan_if;
   import apc_pkg::*;
   logic arm;
   apc_src_t src;
   logic falling;
   logic [1:0] win;
   logic [NUM_IN-1:0] rise;
   logic [NUM_IN-1:0] fall;
   logic in_win;
   logic [DATA_W-1:0] live_pos;
   logic [DATA_W-1:0] live_spd;
   logic flag;
   logic armed;
   logic [DATA_W-1:0] cap_pos;
   logic [DATA_W-1:0] cap_spd;
   modport ctrl (output arm, src, falling, win, rise, fall, in_win,
      live_pos, live_spd, input flag, armed, cap_pos, cap_spd);
   modport chan (input arm, src, falling, win, rise, fall, in_win,
      live_pos, live_spd, output flag, armed, cap_pos, cap_spd);
endinterface : apc_chan_if

// ===== apc_input_filter.sv
`timescale 1ns/10ps
module apc_input_filter import apc_pkg::*; (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic pin_i,
   input wire logic long_i,
   output logic rise_o,
   output logic fall_o
);
   logic sync1_r;
   logic sync2_r;
   logic level_r;
   logic [FILT_CNT_W-1:0] cnt_r;
   logic [FILT_CNT_W-1:0] limit;
   logic settled;

   // threshold follows the selected minimum width
   assign limit = long_i ? FILT_CNT_W'(WIDTH_LONG_CYC)
                         : FILT_CNT_W'(WIDTH_SHORT_CYC);
   assign settled = (cnt_r + 1'b1) >= limit;

   // two-stage synchroniser, then width filter on the second stage
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         level_r <= 1'b0;
         cnt_r <= '0;
         rise_o <= 1'b0;
         fall_o <= 1'b0;
      end else begin
         sync1_r <= pin_i;
         sync2_r <= sync1_r;
         rise_o <= 1'b0;
         fall_o <= 1'b0;
         if (sync2_r == level_r) begin
            cnt_r <= '0; // short pulse rejected
         end else if (settled) begin
            cnt_r <= '0;
            level_r <= sync2_r;
            rise_o <= sync2_r;
            fall_o <= ~sync2_r;
         end else begin
            cnt_r <= cnt_r + 1'b1;
         end
      end
   end
endmodule : apc_input_filter

// ===== apc_capture_chan.sv
`timescale 1ns/10ps
module apc_capture_chan import apc_pkg::*; (
   input wire logic clk_i,
   input wire logic rst_i,
   apc_chan_if.chan ch
);
   apc_state_t state_r;
   apc_src_t src_r;
   logic falling_r;
   logic [1:0] win_r;
   logic [DATA_W-1:0] pos_r;
   logic [DATA_W-1:0] spd_r;
   logic edge_seen;
   logic win_ok;
   logic take;

   // qualified edge of the selected source
   assign edge_seen = falling_r ? ch.fall[src_r] : ch.rise[src_r];
   assign win_ok = (win_r == WIN_NONE)
      || ((win_r == WIN_INSIDE) && ch.in_win)
      || ((win_r == WIN_OUTSIDE) && !ch.in_win);
   assign take = (state_r == ST_ARMED) && edge_seen && win_ok;

   // one-shot capture; a capture in the arming cycle wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= ST_IDLE;
         src_r <= SRC_INDEX;
         falling_r <= 1'b0;
         win_r <= WIN_NONE;
         pos_r <= '0;
         spd_r <= '0;
      end else if (take) begin
         state_r <= ST_DONE;
         pos_r <= ch.live_pos;
         spd_r <= ch.live_spd;
      end else if (ch.arm) begin
         state_r <= ST_ARMED;
         src_r <= ch.src;
         falling_r <= ch.falling;
         win_r <= ch.win;
      end
   end

   assign ch.flag = (state_r == ST_DONE);
   assign ch.armed = (state_r == ST_ARMED);
   assign ch.cap_pos = pos_r;
   assign ch.cap_spd = spd_r;
endmodule : apc_capture_chan

// ===== apc_axis_capture.sv
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/10ps
// Behaviour
// - channel B position register holds the axis position of its event.
// - a capture sets the channel flag and exposes position and speed.
// - each arm command yields at most one capture per channel.
// - the live encoder count is latched in logic on the qualified edge.
// - codes 1-4 arm A, 5 is reserved, 6-13 arm both, 14-17 arm B.
// - code 23 selects a 2.4 us minimum width, code 24 the 0.15 us one.
// - A codes: 1 index rise, 2 index fall, 3 first rise, 4 first fall.
// - adding 256 enables inside windowing, adding 768 outside.
// - inside accepts between the bounds, outside only beyond them.
// - dual codes arm both channels, each with its own result set.
// - codes 6-9 pair first input on A with the index pulse on B.
// - codes 10-13 pair first input on A with second input on B.
// - B codes: 14/15 second index rise/fall, 16/17 second input.
// - channel A position register holds the position of its event.
// - the minimum width applies to every capture input of the axis.
module apc_axis_capture import apc_pkg::*; (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic [3:0] addr_i,
   input wire logic [DATA_W-1:0] wr_data_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [DATA_W-1:0] rd_data_o,
   input wire logic index_pulse_i,
   input wire logic first_capture_input_i,
   input wire logic second_capture_input_i,
   input wire logic second_index_pulse_i,
   input wire logic [DATA_W-1:0] axis_position_i,
   input wire logic [DATA_W-1:0] axis_speed_i,
   output logic chan_a_captured_flag_o,
   output logic chan_b_captured_flag_o
);

   ////////////////////////////////////////////////////////////////////////
   // declarations
   // the block is a register port, four filtered capture inputs and
   // two identical capture engines; all logic runs on the one clock
   // and the only asynchronous inputs are the four capture pins

   logic [DATA_W-1:0] cmd_r;
   logic [DATA_W-1:0] window_open_bound_r;
   logic [DATA_W-1:0] window_close_bound_r;
   logic long_width_r;
   logic [DATA_W-1:0] rd_data_r;
   logic flag_a_r;
   logic flag_b_r;

   logic [NUM_IN-1:0] pins;
   logic [NUM_IN-1:0] rise;
   logic [NUM_IN-1:0] fall;

   logic cmd_wr;
   logic open_wr;
   logic close_wr;
   logic [7:0] code;
   logic [1:0] win_field;
   logic [1:0] win_sel;
   logic is_a;
   logic is_dual;
   logic is_b;
   logic is_long;
   logic is_short;
   logic [7:0] ofs_a;
   logic [7:0] ofs_dual;
   logic [7:0] ofs_b;
   apc_src_t src_a;
   apc_src_t src_b;
   logic falling_a;
   logic falling_b;
   logic arm_a;
   logic arm_b;
   logic in_win;
   logic [DATA_W-1:0] status;
   logic [DATA_W-1:0] rd_mux;
   logic sel_cmd;
   logic sel_open;
   logic sel_close;
   logic sel_status;
   logic sel_pos_a;
   logic sel_pos_b;
   logic sel_spd_a;
   logic sel_spd_b;

   apc_chan_if cha ();
   apc_chan_if chb ();

   ////////////////////////////////////////////////////////////////////////
   // input conditioning
   // each pin goes through its own synchroniser before anything reads
   // it, so a pin that toggles near a clock edge never reaches the
   // engines as a half-resolved level; the filters add a fixed latency
   // that the captured position inherits

   // pin order matches the source enumeration
   assign pins[SRC_INDEX] = index_pulse_i;
   assign pins[SRC_FIRST] = first_capture_input_i;
   assign pins[SRC_SECOND] = second_capture_input_i;
   assign pins[SRC_INDEX2] = second_index_pulse_i;

   // one synchroniser and width filter per capture input
   generate
      for (genvar i = 0; i < NUM_IN; i++) begin : g_filt
         apc_input_filter u_filt (
            .clk_i (core_clk_i),
            .rst_i (rst_i),
            .pin_i (pins[i]),
            .long_i (long_width_r),
            .rise_o (rise[i]),
            .fall_o (fall[i])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // register write decode
   // a write is taken in the one cycle of its strobe; the arm command
   // is decoded straight from the write data so that the engines are
   // armed at the same edge that stores the command for readback

   assign cmd_wr = wr_i && (addr_i == ADDR_CMD);
   assign open_wr = wr_i && (addr_i == ADDR_WIN_OPEN);
   assign close_wr = wr_i && (addr_i == ADDR_WIN_CLOSE);

   // arm command fields
   assign code = wr_data_i[7:0];
   assign win_field = wr_data_i[WIN_LSB+1:WIN_LSB];

   // code classes; code 5 and other gaps fall in none of them
   assign is_a = (code >= CODE_A_FIRST) && (code <= CODE_A_LAST);
   assign is_dual = (code >= CODE_DUAL_FIRST)
      && (code <= CODE_DUAL_LAST);
   assign is_b = (code >= CODE_B_FIRST) && (code <= CODE_B_LAST);
   assign is_long = (code == CODE_WIDTH_LONG);
   assign is_short = (code == CODE_WIDTH_SHORT);

   // offsets within each class pick source and edge by bit
   assign ofs_a = code - CODE_A_FIRST;
   assign ofs_dual = code - CODE_DUAL_FIRST;
   assign ofs_b = code - CODE_B_FIRST;

   // window option: +256 inside, +768 outside, anything else none
   assign win_sel = (win_field == WIN_INSIDE) ? WIN_INSIDE :
                    (win_field == WIN_OUTSIDE) ? WIN_OUTSIDE :
                    WIN_NONE;

   ////////////////////////////////////////////////////////////////////////
   // source and edge selection
   // the arm codes are laid out so that, within the A and B classes, the low
   // offset bit picks the edge and the next bit picks the source; in the dual
   // class bits 1 and 0 pick the A and B edges and bit 2 the B source;
   // decoding by bit keeps this free of a wide table and makes every
   // code of a class reach the same engines

   // channel A: index or first input, code bit order edge then source
   assign src_a = is_dual ? SRC_FIRST :
                  (ofs_a[1] ? SRC_FIRST : SRC_INDEX);
   assign falling_a = is_dual ? ofs_dual[1] : ofs_a[0];

   // channel B: dual codes 6-9 index, 10-13 second input
   assign src_b = is_dual ?
      (ofs_dual[2] ? SRC_SECOND : SRC_INDEX) :
      (ofs_b[1] ? SRC_SECOND : SRC_INDEX2);
   assign falling_b = is_dual ? ofs_dual[0] : ofs_b[0];

   // dual codes arm both channels in the same cycle
   assign arm_a = cmd_wr && (is_a || is_dual);
   assign arm_b = cmd_wr && (is_dual || is_b);

   ////////////////////////////////////////////////////////////////////////
   // position window compare
   // the compare runs every cycle against the live count, so the
   // window is judged at the capture edge itself, not at the arm
   // command; a bound written while armed takes effect at once

   // bounds and position are signed, both bounds inclusive
   assign in_win =
      ($signed(axis_position_i) >= $signed(window_open_bound_r))
      && ($signed(axis_position_i) <= $signed(window_close_bound_r));

   ////////////////////////////////////////////////////////////////////////
   // channel A
   // both engines see all four filtered inputs and pick one by the
   // latched source code; the arm strobe, source and edge differ between them

   assign cha.arm = arm_a;
   assign cha.src = src_a;
   assign cha.falling = falling_a;
   assign cha.win = win_sel;
   assign cha.rise = rise;
   assign cha.fall = fall;
   assign cha.in_win = in_win;
   assign cha.live_pos = axis_position_i;
   assign cha.live_spd = axis_speed_i;

   // channel A capture engine
   apc_capture_chan u_chan_a (
      .clk_i (core_clk_i),
      .rst_i (rst_i),
      .ch (cha.chan)
   );

   ////////////////////////////////////////////////////////////////////////
   // channel B
   // channel B keeps a result set of its own, so a dual code leaves
   // the two captures independent of each other

   assign chb.arm = arm_b;
   assign chb.src = src_b;
   assign chb.falling = falling_b;
   assign chb.win = win_sel;
   assign chb.rise = rise;
   assign chb.fall = fall;
   assign chb.in_win = in_win;
   assign chb.live_pos = axis_position_i;
   assign chb.live_spd = axis_speed_i;

   // channel B capture engine, separate result set
   apc_capture_chan u_chan_b (
      .clk_i (core_clk_i),
      .rst_i (rst_i),
      .ch (chb.chan)
   );

   ////////////////////////////////////////////////////////////////////////
   // configuration registers
   // none of these registers has side effects on a read; the width
   // select changes the filter threshold for inputs already in flight,
   // which may stretch or shorten a pulse that is being counted

   // last arm command, kept for readback
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         cmd_r <= '0;
      end else if (cmd_wr) begin
         cmd_r <= wr_data_i;
      end
   end

   // window bounds
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         window_open_bound_r <= '0;
         window_close_bound_r <= '0;
      end else begin
         if (open_wr) begin
            window_open_bound_r <= wr_data_i;
         end
         if (close_wr) begin
            window_close_bound_r <= wr_data_i;
         end
      end
   end

   // minimum pulse width select, short width after reset
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         long_width_r <= 1'b0;
      end else if (cmd_wr && is_long) begin
         long_width_r <= 1'b1;
      end else if (cmd_wr && is_short) begin
         long_width_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // status and readback
   // status shows the engines' own state; the flag pins lag it by one
   // clock because they are registered once more on the way out

   // live state of both channels and the width select
   always_comb begin
      status = '0;
      status[ST_FLAG_A] = cha.flag;
      status[ST_FLAG_B] = chb.flag;
      status[ST_ARMED_A] = cha.armed;
      status[ST_ARMED_B] = chb.armed;
      status[ST_LONG] = long_width_r;
   end

   // one select line per mapped word address
   assign sel_cmd = (addr_i == ADDR_CMD);
   assign sel_open = (addr_i == ADDR_WIN_OPEN);
   assign sel_close = (addr_i == ADDR_WIN_CLOSE);
   assign sel_status = (addr_i == ADDR_STATUS);
   assign sel_pos_a = (addr_i == ADDR_POS_A);
   assign sel_pos_b = (addr_i == ADDR_POS_B);
   assign sel_spd_a = (addr_i == ADDR_SPD_A);
   assign sel_spd_b = (addr_i == ADDR_SPD_B);

   // read select, unmapped addresses read zero
   assign rd_mux =
      sel_cmd ? cmd_r :
      sel_open ? window_open_bound_r :
      sel_close ? window_close_bound_r :
      sel_status ? status :
      sel_pos_a ? cha.cap_pos :
      sel_pos_b ? chb.cap_pos :
      sel_spd_a ? cha.cap_spd :
      sel_spd_b ? chb.cap_spd :
      '0;

   // the word is cleared again after one cycle so that a master can
   // never mistake a stale word for the answer to a later read
   // read data valid only in the cycle after the strobe
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         rd_data_r <= '0;
      end else if (rd_i) begin
         rd_data_r <= rd_mux;
      end else begin
         rd_data_r <= '0;
      end
   end

   // the extra stage keeps the pins free of decode glitches while an
   // engine changes state, at the cost of one clock of latency
   // captured flags to pins
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         flag_a_r <= 1'b0;
         flag_b_r <= 1'b0;
      end else begin
         flag_a_r <= cha.flag;
         flag_b_r <= chb.flag;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   // every pin of the block comes straight from a flip-flop, so no
   // combinational path runs from an input to an output

   assign rd_data_o = rd_data_r;
   assign chan_a_captured_flag_o = flag_a_r;
   assign chan_b_captured_flag_o = flag_b_r;

endmodule : apc_axis_capture

// ===== apc_axis_capture_monitor.sv
`timescale 1ns/10ps
module apc_axis_capture_monitor import apc_pkg::*; (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic [3:0] addr_i,
   input wire logic [DATA_W-1:0] wr_data_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [DATA_W-1:0] rd_data_o,
   input wire logic chan_a_captured_flag_o,
   input wire logic chan_b_captured_flag_o
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);
   logic cmd, arm_a, arm_b, fa, fb, lng, sht;
   logic pend_a_r, pend_b_r, fa_q_r, fb_q_r, long_r;
   ////////////////////////////////////////////////////////////////////////
   // decode of arm and width commands on the register port
   assign cmd = wr_i && addr_i == ADDR_CMD;
   assign arm_a = cmd && wr_data_i[7:0] inside
      {[CODE_A_FIRST:CODE_A_LAST], [CODE_DUAL_FIRST:CODE_DUAL_LAST]};
   assign arm_b = cmd && wr_data_i[7:0] inside
      {[CODE_DUAL_FIRST:CODE_B_LAST]};
   assign lng = cmd && wr_data_i[7:0] == CODE_WIDTH_LONG;
   assign sht = cmd && wr_data_i[7:0] == CODE_WIDTH_SHORT;
   assign fa = chan_a_captured_flag_o;
   assign fb = chan_b_captured_flag_o;
   // an arm stays pending until its flag rises
   always_ff @(posedge core_clk_i) begin
      fa_q_r <= fa;
      fb_q_r <= fb;
      pend_a_r <= !rst_i && (arm_a || (pend_a_r && !(fa && !fa_q_r)));
      pend_b_r <= !rst_i && (arm_b || (pend_b_r && !(fb && !fb_q_r)));
      long_r <= !rst_i && (lng || (long_r && !sht));
   end
   ////////////////////////////////////////////////////////////////////////
   // re-arm of a finished channel, no arm in flight
   sequence s_rearm_a;
      arm_a && fa && !$past(arm_a) && !$past(arm_a, 2);
   endsequence
   sequence s_rearm_b;
      arm_b && fb && !$past(arm_b) && !$past(arm_b, 2);
   endsequence
   property p_clear_a;
      s_rearm_a |-> ##[1:3] !fa;
   endproperty
   property p_clear_b;
      s_rearm_b |-> ##[1:3] !fb;
   endproperty
   property p_fall_a;
      $fell(fa) |-> $past(arm_a, 2) || $past(arm_a, 3);
   endproperty
   property p_fall_b;
      $fell(fb) |-> $past(arm_b, 2) || $past(arm_b, 3);
   endproperty
   property p_rise_a;
      $rose(fa) |-> pend_a_r;
   endproperty
   property p_rise_b;
      $rose(fb) |-> pend_b_r;
   endproperty
   property p_rd_idle;
      !$past(rd_i) |-> rd_data_o == '0;
   endproperty
   property p_rd_flag;
      rd_i && addr_i == ADDR_STATUS && fa && !$past(wr_i)
         |=> rd_data_o[ST_FLAG_A];
   endproperty
   property p_long;
      rd_i && addr_i == ADDR_STATUS |=> rd_data_o[ST_LONG] == $past(long_r);
   endproperty
   a_clear_a: assert property (p_clear_a) else $error("a not cleared");
   a_clear_b: assert property (p_clear_b) else $error("b not cleared");
   a_fall_a: assert property (p_fall_a) else $error("a fell alone");
   a_fall_b: assert property (p_fall_b) else $error("b fell alone");
   a_rise_a: assert property (p_rise_a) else $error("a unarmed");
   a_rise_b: assert property (p_rise_b) else $error("b unarmed");
   a_rd_idle: assert property (p_rd_idle) else $error("rd not 0");
   a_rd_flag: assert property (p_rd_flag) else $error("status a");
   a_long: assert property (p_long) else $error("width bit");
endmodule : apc_axis_capture_monitor

bind apc_axis_capture apc_axis_capture_monitor u_mon (.core_clk_i, .rst_i,
   .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o, .chan_a_captured_flag_o,
   .chan_b_captured_flag_o);

// ===== apc_sensor_model.sv
`timescale 1ns/10ps
module apc_sensor_model import apc_pkg::*; (
   input wire logic clk_i,
   output logic [3:0] pins_o,
   output logic [DATA_W-1:0] pos_o,
   output logic [DATA_W-1:0] spd_o
);
   logic ld_r = 1'b0;
   logic [DATA_W-1:0] ld_pos_r = '0;
   // pins idle low, encoder starts at zero
   initial begin
      pins_o = '0;
      pos_o = '0;
      spd_o = '0;
   end
   // encoder count moves by the speed every clock
   always @(posedge clk_i) begin
      pos_o <= ld_r ? ld_pos_r : pos_o + spd_o;
   end
   task automatic set_motion(input logic [DATA_W-1:0] p,
                             input logic [DATA_W-1:0] s);
      @(posedge clk_i);
      ld_pos_r <= p;
      spd_o <= s;
      ld_r <= 1'b1;
      @(posedge clk_i);
      ld_r <= 1'b0;
   endtask : set_motion
   // one high pulse of w clocks, then g quiet clocks
   task automatic pulse(input int k, input int w, input int g,
                        output logic [DATA_W-1:0] pr,
                        output logic [DATA_W-1:0] pf);
      @(posedge clk_i);
      pins_o[k] <= 1'b1;
      pr = pos_o;
      repeat (w) @(posedge clk_i);
      pins_o[k] <= 1'b0;
      pf = pos_o;
      repeat (g) @(posedge clk_i);
   endtask : pulse
endmodule : apc_sensor_model

// ===== apc_axis_capture_tb.sv
`timescale 1ns/10ps
`define CHK(nm, ex, ac) begin \
   total_checks++; \
   if ((ac) !== (ex)) begin \
      failures++; \
      $display("MISMATCH %s exp %0h got %0h", nm, ex, ac); \
   end \
end
module apc_axis_capture_tb import apc_pkg::*; ();
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [3:0] addr_i = '0;
   logic [DATA_W-1:0] wr_data_i = '0;
   logic [DATA_W-1:0] rd_data_o, pos, spd;
   logic [3:0] pins;
   logic flag_a, flag_b;
   int failures = 0;
   int total_checks = 0;
   int cyc = 0;
   always #25 core_clk_i = ~core_clk_i;
   apc_axis_capture u_dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
      .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
      .rd_data_o(rd_data_o), .index_pulse_i(pins[0]),
      .first_capture_input_i(pins[1]), .second_capture_input_i(pins[2]),
      .second_index_pulse_i(pins[3]), .axis_position_i(pos),
      .axis_speed_i(spd), .chan_a_captured_flag_o(flag_a),
      .chan_b_captured_flag_o(flag_b));
   apc_sensor_model u_sens (.clk_i(core_clk_i), .pins_o(pins), .pos_o(pos),
      .spd_o(spd));
   ////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [3:0] a, input logic [DATA_W-1:0] d);
      @(posedge core_clk_i);
      addr_i <= a;
      wr_data_i <= d;
      wr_i <= 1'b1;
      @(posedge core_clk_i);
      wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [DATA_W-1:0] d);
      @(posedge core_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge core_clk_i);
      rd_i <= 1'b0;
      #1 d = rd_data_o;
   endtask : rd
   // capture must land a few clocks after the pin edge
   task automatic near(string nm, logic [DATA_W-1:0] v,
                       logic [DATA_W-1:0] e, int s);
      logic [DATA_W-1:0] df;
      df = v - e;
      `CHK(nm, 1'b1, df >= 3 * s && df <= 10 * s)
   endtask : near
   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : stop_test
   // hang guard
   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         stop_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      logic [DATA_W-1:0] v, va, vb, px, py;
      logic [DATA_W-1:0] pr [4];
      logic [DATA_W-1:0] pf [4];
      logic ea, eb, fa, fb;
      int ka, kb, s;
      repeat (3) @(posedge core_clk_i);
      rst_i <= 1'b0;
      for (int a = 0; a < 10; a++) begin
         rd(4'(a), v);
         `CHK("reset value", '0, v)
      end
      $display("test reset done");
      ea = 1'b0;
      eb = 1'b0;
      for (int c = 1; c <= 17; c++) begin
         ka = c < 5 ? (c < 3 ? 0 : 1) : (c > 5 && c < 14 ? 1 : -1);
         fa = c < 5 ? c % 2 == 0 : c inside {8, 9, 12, 13};
         kb = c < 6 ? -1 : c < 10 ? 0 : c < 14 ? 2 : c < 16 ? 3 : 2;
         fb = c % 2 == 1;
         s = c % 3 + 1;
         u_sens.set_motion(32'(c * 4096), 32'(s));
         wr(ADDR_CMD, 32'(c));
         for (int k = 0; k < 4; k++) u_sens.pulse(k, 10, 20, pr[k], pf[k]);
         ea = ea | ka >= 0;
         eb = eb | kb >= 0;
         `CHK("flag a", ea, flag_a)
         `CHK("flag b", eb, flag_b)
         rd(ADDR_POS_A, va);
         rd(ADDR_POS_B, vb);
         if (ka >= 0) near("pos a", va, fa ? pf[ka] : pr[ka], s);
         if (kb >= 0) near("pos b", vb, fb ? pf[kb] : pr[kb], s);
         rd(ADDR_SPD_B, v);
         if (kb >= 0) `CHK("speed b", 32'(s), v)
         rd(ADDR_SPD_A, v);
         if (ka >= 0) `CHK("speed a", 32'(s), v)
         for (int k = 0; k < 4; k++) u_sens.pulse(k, 10, 20, px, py);
         rd(ADDR_POS_A, v);
         `CHK("pos a kept", va, v)
         rd(ADDR_POS_B, v);
         `CHK("pos b kept", vb, v)
      end
      $display("test codes done");
      wr(ADDR_WIN_OPEN, 32'd400);
      wr(ADDR_WIN_CLOSE, 32'd600);
      for (int i = 0; i < 4; i++) begin
         u_sens.set_motion(32'(600 + i % 2), '0);
         wr(ADDR_CMD, i < 2 ? 32'h103 : 32'h303);
         u_sens.pulse(1, 10, 20, px, py);
         `CHK("window", (i < 2) == (i % 2 == 0), flag_a)
      end
      $display("test window done");
      wr(ADDR_CMD, 32'(CODE_WIDTH_LONG));
      wr(ADDR_CMD, 32'd16);
      u_sens.pulse(2, 20, 60, px, py);
      `CHK("long reject", 1'b0, flag_b)
      u_sens.pulse(2, 60, 60, px, py);
      `CHK("long accept", 1'b1, flag_b)
      rd(ADDR_STATUS, v);
      `CHK("long bit", 1'b1, v[ST_LONG])
      wr(ADDR_CMD, 32'(CODE_WIDTH_SHORT));
      wr(ADDR_CMD, 32'd3);
      u_sens.pulse(1, 1, 20, px, py);
      `CHK("short reject", 1'b0, flag_a)
      u_sens.pulse(1, 5, 20, px, py);
      `CHK("short accept", 1'b1, flag_a)
      rd(ADDR_STATUS, v);
      `CHK("short bit", 1'b0, v[ST_LONG])
      $display("test width done");
      stop_test();
   end
endmodule : apc_axis_capture_tb
